// File: core/rsm_pkg.sv
/*
 * Constants and types shared by the reset strap capture block.
 * Assumes one 100 MHz clock and a synchronous, active-high reset.
 */
package rsm_pkg;
   // Strap pin count and positions in the pin vectors
   localparam int STRAP_COUNT = 7;
   localparam int PIN_BOOT_MEM_SEL = 0;   // boot_memory_select_pin
   localparam int PIN_BUS_MASTER = 1;     // bus_master_pin
   localparam int PIN_TIMER_ZERO = 2;     // timer_zero_expired_pin
   localparam int PIN_BUS_LOCK = 3;       // bus_lock_pin
   localparam int PIN_LINK_ONE_DONE = 4;  // link_one_block_done_out
   localparam int PIN_TEST_TWO = 5;
   localparam int PIN_TEST_THREE = 6;

   // Default levels and pad pulls while reset is active
   localparam logic [6:0] STRAP_DEFAULT = 7'h70;
   localparam logic [6:0] PULLUP_RESET_MASK = 7'h70;
   localparam logic [6:0] PULLDOWN_RESET_MASK = 7'h0f;
   // Pads kept on a pull-up once normal functions resume
   localparam logic [6:0] PULLUP_NORMAL_MASK = 7'h09;

   // Pin hand-back delay after the capture edge
   localparam int CLK_PERIOD_NS = 10;
   localparam int RELEASE_TIME_NS = 30;
   localparam int RELEASE_CYCLES_INT =
      (RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] RELEASE_CYCLES = RELEASE_CYCLES_INT[3:0];

   // Link receive widths
   localparam logic [2:0] LINK_WIDTH_NARROW = 3'h1;
   localparam logic [2:0] LINK_WIDTH_WIDE = 3'h4;

   // Register offsets and reset values
   localparam logic [7:0] OFS_SYSTEM_CONFIG = 8'h00;
   localparam logic [7:0] OFS_SDRAM_CONFIG = 8'h04;
   localparam logic [7:0] OFS_STRAP_STATUS = 8'h08;
   localparam logic [31:0] SYSTEM_CONFIG_RESET = 32'h0000_0000;
   localparam logic [31:0] SDRAM_CONFIG_RESET = 32'h0000_0000;

   // Captured strap levels, one bit per strap
   typedef struct packed {
      logic [2:0] test_level;   // Three factory test straps
      logic cfg_always_wr;      // config_reg_write_policy_strap
      logic link_rx_wide;       // link_rx_width_strap
      logic irq_edge_en;        // interrupt_enable_strap
      logic boot_wait;          // boot_source_strap
   } rsm_mode_s;

   localparam rsm_mode_s MODE_DEFAULT = rsm_mode_s'(STRAP_DEFAULT);
endpackage

// File: core/rsm_strap_capture.sv
/*
 * Reset strap capture: samples the shared strap pins around reset,
 * latches the operating modes and guards the two config registers.
 * Assumes the pads resolve pin_in from pulls and drivers, and that
 * the core supplies normal-function drive on func_out/func_oe_n.
 */
// Chosen here: the register offsets and the plain strobed port.
// Contract
// - While in reset the strap inputs are sampled and the captured levels select the modes.
// - A strap left undriven is captured at the default set by its internal pull.
// - Boot strap 0 boots from EPROM at once, 1 idles awaiting an external boot.
// - Interrupt strap 0 leaves the four lines disabled and level, 1 enables them edge-sensitive.
// - Link width strap 0 gives 1-bit receive width, 1 gives 4-bit.
// - Write-policy strap 0 allows one write per config register after reset, 1 allows any.
// - Straps latch on the reset release edge and the pins then return to normal use.
`timescale 1ns/1ns
module rsm_strap_capture (
   input wire logic clk,
   input wire logic rst,
   input wire logic [rsm_pkg::STRAP_COUNT-1:0] pin_in,
   output logic [rsm_pkg::STRAP_COUNT-1:0] pin_out,
   output logic [rsm_pkg::STRAP_COUNT-1:0] pin_oe_n,
   output logic [rsm_pkg::STRAP_COUNT-1:0] pull_up_en,
   output logic [rsm_pkg::STRAP_COUNT-1:0] pull_down_en,
   input wire logic [rsm_pkg::STRAP_COUNT-1:0] func_out,
   input wire logic [rsm_pkg::STRAP_COUNT-1:0] func_oe_n,
   output rsm_pkg::rsm_mode_s mode,
   output logic mode_valid,
   output logic pins_released,
   output logic boot_from_eprom,
   output logic boot_wait_external,
   output logic irq_enable,
   output logic irq_edge_sense,
   output logic [2:0] link_rx_width,
   output logic test_strap_fault,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic [31:0] system_config,
   output logic [31:0] sdram_config
);
   import rsm_pkg::*;

   logic [STRAP_COUNT-1:0] sync1;
   logic [STRAP_COUNT-1:0] sync2;
   logic was_rst;
   logic next_was_rst;
   rsm_mode_s next_mode;
   logic next_mode_valid;
   logic [3:0] release_cnt;
   logic [3:0] next_release_cnt;
   logic next_pins_released;
   logic [STRAP_COUNT-1:0] next_pin_out;
   logic [STRAP_COUNT-1:0] next_pin_oe_n;
   logic [STRAP_COUNT-1:0] next_pull_up_en;
   logic [STRAP_COUNT-1:0] next_pull_down_en;
   logic sys_written;
   logic sdr_written;
   logic next_sys_written;
   logic next_sdr_written;
   logic [31:0] next_system_config;
   logic [31:0] next_sdram_config;
   logic [31:0] next_rdata;
   logic capture_edge;

   // Write permission under the latched policy
   function automatic logic write_allowed(input logic valid,
                                          input logic always_wr,
                                          input logic written);
      write_allowed = valid && (always_wr || !written);
   endfunction

   // Pin synchroniser, free running so it tracks pins during reset
   always_ff @(posedge clk) begin
      sync1 <= pin_in;
      sync2 <= sync1;
   end

   // First cycle out of reset is the capture edge
   assign capture_edge = was_rst && !rst;

   // Capture and hold of the strap levels, then pin hand-back
   always_comb begin
      next_was_rst = rst;
      next_mode = mode;
      next_mode_valid = mode_valid;
      next_release_cnt = release_cnt;
      next_pins_released = pins_released;
      if (rst) begin
         next_mode = MODE_DEFAULT;
         next_mode_valid = 1'b0;
         next_release_cnt = 4'h0;
         next_pins_released = 1'b0;
      end else if (capture_edge) begin
         next_mode = rsm_mode_s'(sync2);
         next_mode_valid = 1'b1;
         next_release_cnt = RELEASE_CYCLES;
      end else if (release_cnt != 4'h0) begin
         next_release_cnt = release_cnt - 4'h1;
         if (release_cnt == 4'h1) begin
            next_pins_released = 1'b1;
         end
      end
      // Otherwise mode stays untouched until the next reset
   end

   always_ff @(posedge clk) begin
      was_rst <= next_was_rst;
      mode <= next_mode;
      mode_valid <= next_mode_valid;
      release_cnt <= next_release_cnt;
      pins_released <= next_pins_released;
   end

   // Pad drive and pulls: quiet with strap pulls until hand-back
   always_comb begin
      if (next_pins_released) begin
         next_pin_out = func_out;
         next_pin_oe_n = func_oe_n;
         next_pull_up_en = PULLUP_NORMAL_MASK;
         next_pull_down_en = '0;
      end else begin
         next_pin_out = '0;
         next_pin_oe_n = '1;
         next_pull_up_en = PULLUP_RESET_MASK;
         next_pull_down_en = PULLDOWN_RESET_MASK;
      end
   end

   always_ff @(posedge clk) begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
      pull_up_en <= next_pull_up_en;
      pull_down_en <= next_pull_down_en;
   end

   // Mode outputs toward boot, interrupt and link logic
   assign boot_from_eprom = mode_valid && !mode.boot_wait;
   assign boot_wait_external = mode_valid && mode.boot_wait;
   assign irq_enable = mode.irq_edge_en;
   assign irq_edge_sense = mode.irq_edge_en;
   assign link_rx_width = mode.link_rx_wide ? LINK_WIDTH_WIDE
                                            : LINK_WIDTH_NARROW;
   // Flags a board that overdrove a test strap
   assign test_strap_fault = mode_valid && (mode.test_level != 3'h7);

   // Config registers with the latched write policy, and read port
   always_comb begin
      next_system_config = system_config;
      next_sdram_config = sdram_config;
      next_sys_written = sys_written;
      next_sdr_written = sdr_written;
      next_rdata = 32'h0000_0000;
      if (rst) begin
         next_system_config = SYSTEM_CONFIG_RESET;
         next_sdram_config = SDRAM_CONFIG_RESET;
         next_sys_written = 1'b0;
         next_sdr_written = 1'b0;
      end else if (wr) begin
         if (addr == OFS_SYSTEM_CONFIG &&
             write_allowed(mode_valid, mode.cfg_always_wr,
                           sys_written)) begin
            next_system_config = wdata;
            next_sys_written = 1'b1;
         end
         if (addr == OFS_SDRAM_CONFIG &&
             write_allowed(mode_valid, mode.cfg_always_wr,
                           sdr_written)) begin
            next_sdram_config = wdata;
            next_sdr_written = 1'b1;
         end
      end else if (rd) begin
         unique case (addr)
            OFS_SYSTEM_CONFIG: next_rdata = system_config;
            OFS_SDRAM_CONFIG: next_rdata = sdram_config;
            OFS_STRAP_STATUS: next_rdata = {20'h0, test_strap_fault,
               sdr_written, sys_written, pins_released, mode_valid,
               mode};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      system_config <= next_system_config;
      sdram_config <= next_sdram_config;
      sys_written <= next_sys_written;
      sdr_written <= next_sdr_written;
      rdata <= next_rdata;
   end

   // Checks on capture, hold, hand-back and write policy
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_capture_levels: assert property (
      capture_edge |=> (mode == rsm_mode_s'($past(sync2))) && mode_valid)
      else $error("strap levels not captured at release");

   chk_default_pulls: assert property (
      !pins_released |-> pull_up_en == PULLUP_RESET_MASK &&
                         pull_down_en == PULLDOWN_RESET_MASK)
      else $error("strap pulls wrong before hand-back");

   chk_boot_select: assert property (
      capture_edge |=> boot_wait_external == $past(sync2[PIN_BOOT_MEM_SEL])
                       && boot_from_eprom != boot_wait_external)
      else $error("boot selection does not follow strap");

   chk_irq_config: assert property (
      capture_edge |=> irq_edge_sense == $past(sync2[PIN_BUS_MASTER])
                       && irq_enable == irq_edge_sense)
      else $error("interrupt setup does not follow strap");

   chk_link_width: assert property (
      capture_edge ##1 mode.link_rx_wide |-> link_rx_width == 3'h4)
      else $error("link width not 4 bits for set strap");

   chk_one_shot_write: assert property (
      wr && addr == OFS_SYSTEM_CONFIG && sys_written &&
      !mode.cfg_always_wr |=> $stable(system_config))
      else $error("second config write not refused");

   chk_always_write: assert property (
      wr && addr == OFS_SDRAM_CONFIG && mode_valid &&
      mode.cfg_always_wr |=> sdram_config == $past(wdata))
      else $error("config write lost under open policy");

   chk_release_timing: assert property (
      capture_edge |-> (!pins_released && pin_oe_n == '1)[*4]
                       ##1 pins_released)
      else $error("pins not handed back on time");

   chk_mode_hold: assert property (
      mode_valid && !capture_edge |=> $stable(mode) && mode_valid)
      else $error("latched mode changed without reset");

   chk_narrow_link: assert property (
      capture_edge ##1 !mode.link_rx_wide |-> link_rx_width == 3'h1)
      else $error("link width not 1 bit for clear strap");

   // Pads stay quiet until hand-back, then carry the core's drive
   chk_reset_pads: assert property (
      !pins_released |-> pin_oe_n == '1 && pin_out == '0)
      else $error("pads driven before hand-back");

   chk_pad_handback: assert property (
      pins_released |-> pin_oe_n == $past(func_oe_n) &&
                        pin_out == $past(func_out))
      else $error("pads not following normal drive");

   chk_normal_pulls: assert property (
      pins_released |-> pull_up_en == PULLUP_NORMAL_MASK &&
                        pull_down_en == '0)
      else $error("pad pulls wrong after hand-back");

   // Write policy on the second register as well, and first write on the first
   chk_sdram_one_shot: assert property (
      wr && addr == OFS_SDRAM_CONFIG && sdr_written &&
      !mode.cfg_always_wr |=> $stable(sdram_config))
      else $error("second sdram config write not refused");

   chk_first_write: assert property (
      wr && addr == OFS_SYSTEM_CONFIG && mode_valid && !sys_written
      |=> system_config == $past(wdata) && sys_written)
      else $error("first config write lost");

   // Read data stands one cycle after the strobe, zero otherwise
   chk_read_config: assert property (
      rd && !wr && addr == OFS_SDRAM_CONFIG |=>
         rdata == $past(sdram_config))
      else $error("config read data wrong");

   chk_read_idle: assert property (
      !rd |=> rdata == 32'h0000_0000)
      else $error("read data not cleared");

   chk_status_read: assert property (
      rd && !wr && addr == OFS_STRAP_STATUS |=>
         rdata[6:0] == $past(mode) && rdata[7] == $past(mode_valid))
      else $error("status read does not show captured straps");

   // Scenarios worth seeing at least once

   cov_external_boot: cover property (capture_edge ##1 boot_wait_external);
   cov_refused_write: cover property (
      wr && addr == OFS_SYSTEM_CONFIG && sys_written &&
      !mode.cfg_always_wr);
   cov_open_rewrite: cover property (
      wr && addr == OFS_SDRAM_CONFIG && sdr_written && mode.cfg_always_wr);
   cov_wide_link: cover property (mode_valid && link_rx_width == 3'h4);
   cov_test_fault: cover property (capture_edge ##1 test_strap_fault);
endmodule // rsm_strap_capture

// File: tb/rsm_board_model.sv
/*
 * Board side of the strap pins: strap drivers, pad pulls, wire level.
 * Assumes the pad controls of the strap capture block, one clock.
 */
`timescale 1ns/1ns
module rsm_board_model (
   input wire logic clk,
   input wire logic [6:0] ext_en,
   input wire logic [6:0] ext_lvl,
   input wire logic [6:0] pin_out,
   input wire logic [6:0] pin_oe_n,
   input wire logic [6:0] pull_up_en,
   input wire logic [6:0] pull_down_en,
   output logic [6:0] pin_in
);
   logic [6:0] last;
   // Wire level: pad drive, strap driver, pulls, else drifting
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         if (!pin_oe_n[i])
            pin_in[i] = pin_out[i];
         else if (ext_en[i])
            pin_in[i] = ext_lvl[i];
         else if (pull_up_en[i])
            pin_in[i] = 1'b1;
         else if (pull_down_en[i])
            pin_in[i] = 1'b0;
         else
            pin_in[i] = ~last[i];
      end
   end
   // Previous level, so a floating pin never looks held
   always_ff @(posedge clk) last <= pin_in;
endmodule // rsm_board_model

// File: tb/tb_top.sv
/*
 * Self-checking bench for the reset strap capture block.
 * Assumes the board model drives the pads; straps from an LFSR.
 */
`timescale 1ns/1ns
module tb_top;
   import rsm_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, seed = 32'h5a6d94d5, v, exp_c;
   logic [6:0] ext_en = 7'h00, ext_lvl = 7'h00, exp_m;
   logic [6:0] func_out = 7'h00, func_oe_n = 7'h7f;
   logic [6:0] pin_in, pin_out, pin_oe_n, pull_up_en, pull_down_en;
   rsm_mode_s mode;
   logic mode_valid, pins_released, boot_from_eprom, boot_wait_external;
   logic irq_enable, irq_edge_sense, test_strap_fault;
   logic [2:0] link_rx_width;
   logic [31:0] rdata, system_config, sdram_config;
   int n_fail = 0, compares = 0, cyc = 0;
   // Clock
   always #5 clk = ~clk;
   rsm_strap_capture dut_u (.clk(clk), .rst(rst), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
      .pull_down_en(pull_down_en), .func_out(func_out),
      .func_oe_n(func_oe_n), .mode(mode), .mode_valid(mode_valid),
      .pins_released(pins_released), .boot_from_eprom(boot_from_eprom),
      .boot_wait_external(boot_wait_external), .irq_enable(irq_enable),
      .irq_edge_sense(irq_edge_sense), .link_rx_width(link_rx_width),
      .test_strap_fault(test_strap_fault), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .system_config(system_config),
      .sdram_config(sdram_config));
   rsm_board_model board_u (.clk(clk), .ext_en(ext_en), .ext_lvl(ext_lvl),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
      .pull_down_en(pull_down_en), .pin_in(pin_in));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic close_out;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // Reset with given straps, then check capture, hand-back, registers
   task automatic boot(input logic [6:0] en, input logic [6:0] lvl);
      @(posedge clk);
      rst <= 1'b1;
      ext_en <= en;
      ext_lvl <= lvl;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      exp_m = (en & lvl) | (~en & STRAP_DEFAULT);
      repeat (2) @(posedge clk);
      // Pins change once captured; the latched modes must not follow
      ext_lvl <= ~lvl;
      func_out <= seed[6:0];
      func_oe_n <= seed[13:7];
      #1 chk("mode", mode, exp_m);
      chk("valid", mode_valid, 1'b1);
      chk("eprom", boot_from_eprom, !exp_m[0]);
      chk("waitx", boot_wait_external, exp_m[0]);
      chk("irq", {irq_enable, irq_edge_sense}, {2{exp_m[1]}});
      chk("width", link_rx_width, exp_m[2] ? 32'h4 : 32'h1);
      chk("fault", test_strap_fault, exp_m[6:4] != 3'h7);
      @(posedge clk);
      #1 chk("early", pins_released, 1'b0);
      chk("rup", pull_up_en, PULLUP_RESET_MASK);
      chk("rdn", pull_down_en, PULLDOWN_RESET_MASK);
      @(posedge clk);
      #1 chk("freed", pins_released, 1'b1);
      chk("oe", pin_oe_n, func_oe_n);
      chk("out", pin_out, func_out);
      chk("up", pull_up_en, PULLUP_NORMAL_MASK);
      chk("dn", pull_down_en, 7'h00);
      chk("hold", mode, exp_m);
      for (int k = 0; k < 2; k++) begin
         wr_reg(8'(k * 4), seed);
         wr_reg(8'(k * 4), ~seed);
         rd_reg(8'(k * 4), v);
         exp_c = exp_m[3] ? ~seed : seed;
         chk("cfg", v, exp_c);
         chk("creg", k ? sdram_config : system_config, exp_c);
      end
      rd_reg(8'h08, v);
      chk("stat", v, {20'h0, exp_m[6:4] != 3'h7, 4'hf, exp_m});
      rd_reg(8'h0c, v);
      chk("unmap", v, 32'h0);
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         n_fail++;
         close_out();
      end
   end
   // Defaults, random straps, then test straps overdriven
   initial begin
      boot(7'h00, 7'h00);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         boot({3'h0, seed[3:0]}, seed[10:4]);
      end
      boot(7'h7f, 7'h0f);
      close_out();
   end
endmodule // tb_top
